// File: tb/rxsc_card.sv
// card model: sends one framed bit stream toward the reader
`timescale 1ns/1ps
module rxsc_card (
    // clock
    input  wire logic clk_i,
    // stream toward the block
    output logic      rx_start_o,
    output logic      rx_end_o,
    output logic      rx_bit_valid_o,
    output logic      rx_bit_o,
    output logic      rx_bit_coll_o
);
    initial begin
        rx_start_o     = 1'b0;
        rx_end_o       = 1'b0;
        rx_bit_valid_o = 1'b0;
        rx_bit_o       = 1'b0;
        rx_bit_coll_o  = 1'b0;
    end
    // start pulse, n bits back to back (collision at index ci), end pulse
    task automatic frame(input int n, input logic [127:0] b, input int ci);
        @(posedge clk_i) rx_start_o <= 1'b1;
        @(posedge clk_i) rx_start_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_bit_valid_o <= 1'b1;
            rx_bit_o       <= b[i];
            rx_bit_coll_o  <= (i == ci);
            @(posedge clk_i);
        end
        // line between frames shows the inverse of the last bit
        rx_bit_valid_o <= 1'b0;
        rx_bit_o       <= ~rx_bit_o;
        rx_bit_coll_o  <= 1'b0;
        rx_end_o       <= 1'b1;
        @(posedge clk_i) rx_end_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// File: tb/rxsc_regs_asserts.sv
// checker watching the ports of the register bank
`timescale 1ns/1ps
module rxsc_regs_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic card_auth_set_i,
    input wire logic cipher_active_o,
    input wire logic rx_start_i,
    input wire logic rx_end_i,
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_coll_i,
    input wire logic rx_byte_valid_o,
    input wire logic collision_detected_o,
    input wire logic integrity_error_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a new bus request and its single-cycle answer
    sequence req_s; cyc_i && stb_i && !ack_o; endsequence
    sequence ack_s; ack_o ##1 !ack_o; endsequence
    bus_ack_a: assert property (req_s |=> ack_s)
        else $error("bus answer missing or too long");
    cipher_set_a: assert property (card_auth_set_i |=> cipher_active_o)
        else $error("auth did not set cipher flag");
    cipher_rise_a: assert property ($rose(cipher_active_o)
        |-> $past(card_auth_set_i)) else $error("cipher set w/o auth");
    coll_set_a: assert property (rx_bit_valid_i && rx_bit_coll_i
        |=> collision_detected_o) else $error("collision not flagged");
    coll_hold_a: assert property (collision_detected_o && !rx_start_i
        |=> collision_detected_o) else $error("collision flag lost");
    start_clr_a: assert property (rx_start_i && !rx_bit_valid_i
        |=> !collision_detected_o && !integrity_error_o)
        else $error("flags not cleared at start");
    integ_cause_a: assert property ($rose(integrity_error_o)
        |-> $past(rx_bit_valid_i && rx_bit_coll_i))
        else $error("integrity error without collision");
    byte_cause_a: assert property ($rose(rx_byte_valid_o)
        |-> $past(rx_bit_valid_i || rx_end_i))
        else $error("byte out without bit or end");
endmodule
bind rxsc_regs rxsc_regs_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .ack_o, .card_auth_set_i, .cipher_active_o, .rx_start_i, .rx_end_i,
    .rx_bit_valid_i, .rx_bit_coll_i, .rx_byte_valid_o,
    .collision_detected_o, .integrity_error_o);

// File: tb/tb.sv
// self-checking bench for the receive status and collision bank
`timescale 1ns/1ps
module tb;
    import rxsc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1;  // clock and reset
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0; // bus request
    logic [9:0]  adr_i = 10'h000;             // byte address
    logic [3:0]  sel_i = 4'hF;                // byte enables
    logic [31:0] dat_i = 32'h0, dat_o, q;     // bus data
    logic        ack_o, auth = 1'b0, st, en, bv, bt, bc;
    logic [2:0]  state = 3'h0;                // engine state
    logic        byv_o, cd_o, ie_o, ca_o, irq_o;
    logic [7:0]  byte_o;
    logic [7:0]  bytes[$];                    // bytes seen on the stream
    int          fails = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    rxsc_card card (.clk_i(clk_i), .rx_start_o(st), .rx_end_o(en),
        .rx_bit_valid_o(bv), .rx_bit_o(bt), .rx_bit_coll_o(bc));
    rxsc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .txrx_state_i(state),
        .card_auth_set_i(auth), .rx_start_i(st), .rx_end_i(en),
        .rx_bit_valid_i(bv), .rx_bit_i(bt), .rx_bit_coll_i(bc),
        .rx_byte_valid_o(byv_o), .rx_byte_o(byte_o),
        .collision_detected_o(cd_o), .integrity_error_o(ie_o),
        .cipher_active_o(ca_o), .irq_o(irq_o));
    // record every byte handed out
    always @(posedge clk_i) if (byv_o === 1'b1) bytes.push_back(byte_o);
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    // one classic wishbone cycle; only the watchdog ends a hung wait
    task automatic wb(logic w, logic [7:0] i, logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {i, 2'b00};
        dat_i <= {24'h0, d};
        do begin @(posedge clk_i); end
        while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic rd(string nm, logic [7:0] i, logic [31:0] e);
        wb(1'b0, i, 8'h00);
        chk(nm, q, e);
    endtask
    task automatic t_reset();
        rd("bitctrl", RXSC_IDX_BITCTRL, 32'h80);
        rd("status", RXSC_IDX_STATUS, 32'h00);
        rd("coll", RXSC_IDX_COLL, 32'h00);
        rd("unmapped", 8'h3F, 32'h00);
        $display("test reset done");
    endtask
    task automatic t_state();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            state <= c;
            wb(1'b1, RXSC_IDX_STATUS, 8'h07); // state is read-only
            rd("state", RXSC_IDX_STATUS, (c == 3'b100) ? 0 : c);
        end
        state <= 3'h0;
        $display("test state done");
    endtask
    task automatic t_cipher();
        wb(1'b1, RXSC_IDX_STATUS, 8'h20);
        rd("cipher host set", RXSC_IDX_STATUS, 32'h00);
        @(posedge clk_i) auth <= 1'b1;
        @(posedge clk_i) auth <= 1'b0;
        rd("cipher auth", RXSC_IDX_STATUS, 32'h20);
        wb(1'b1, RXSC_IDX_STATUS, 8'h00);
        chk("cipher off", ca_o, 0);
        $display("test cipher done");
    endtask
    task automatic t_byte();
        bytes = {};
        card.frame(8, 128'hA5, 99);
        chk("byte", bytes[0], 8'hA5);
        rd("bitctrl byte", RXSC_IDX_BITCTRL, 32'h80);
        rd("coll none", RXSC_IDX_COLL, 32'h00);
        wb(1'b1, RXSC_IDX_BITCTRL, 8'hF0);
        bytes = {};
        card.frame(9, 128'h3, 99);
        chk("align7 first", bytes[0][7], 1);
        chk("align7 second", bytes[1][0], 1);
        rd("last bits", RXSC_IDX_BITCTRL, 32'hF0);
        $display("test byte done");
    endtask
    task automatic t_coll();
        wb(1'b1, RXSC_IDX_IRQ_MASK, 8'h01);
        wb(1'b1, RXSC_IDX_BITCTRL, 8'h48);
        bytes = {};
        card.frame(8, 128'hF7, 3);
        chk("first byte", bytes[0] & 8'hF0, 8'h70);
        chk("zeroed", bytes[1][3:0], 0);
        chk("flags", {cd_o, ie_o, irq_o}, 3'b111);
        rd("coll pos", RXSC_IDX_COLL, 32'h87);
        rd("last bits", RXSC_IDX_BITCTRL, 32'h4C);
        rd("irq stat", RXSC_IDX_IRQ_STAT, 32'h07);
        wb(1'b1, RXSC_IDX_IRQ_STAT, 8'h01);
        rd("irq left", RXSC_IDX_IRQ_STAT, 32'h06);
        // the level follows the cleared status one cycle later
        @(posedge clk_i);
        chk("irq low", irq_o, 0);
        card.frame(0, 128'h0, 99);
        rd("coll cleared", RXSC_IDX_COLL, 32'h00);
        chk("flag cleared", cd_o, 0);
        wb(1'b1, RXSC_IDX_BITCTRL, 8'h80);
        card.frame(64, 128'h0, 63);
        rd("last in range", RXSC_IDX_COLL, 32'hBF);
        bytes = {};
        card.frame(65, {63'h0, 1'b1, 64'h0}, 64);
        chk("kept after coll", bytes[8], 8'h01);
        wb(1'b0, RXSC_IDX_COLL, 8'h00);
        chk("beyond 64", q[7], 0);
        chk("coll flag", cd_o, 1);
        chk("no integ", ie_o, 0);
        $display("test collision done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_state();
        t_cipher();
        t_byte();
        t_coll();
        end_sim();
    end
endmodule

// File: verilog/rxsc_pkg.sv
// shared constants for the receive status and collision register bank
package rxsc_pkg;
    // printed register offsets (indices); byte address is four times these
    localparam logic [7:0] RXSC_IDX_STATUS   = 8'h0B;
    localparam logic [7:0] RXSC_IDX_BITCTRL  = 8'h0C;
    localparam logic [7:0] RXSC_IDX_COLL     = 8'h0D;
    // interrupt registers at chosen indices
    localparam logic [7:0] RXSC_IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] RXSC_IDX_IRQ_MASK = 8'h21;
    // field positions
    localparam int RXSC_CIPHER_BIT   = 5;
    localparam int RXSC_KEEP_BIT     = 7;
    localparam int RXSC_ALIGN_LSB    = 4;
    localparam int RXSC_COLLISION_AS_INTEGRITY_ERROR_BIT   = 3;
    localparam int RXSC_CPV_BIT      = 7;
    // interrupt status bit positions
    localparam int RXSC_IRQ_COLL     = 0;
    localparam int RXSC_IRQ_INTEG    = 1;
    localparam int RXSC_IRQ_DONE     = 2;
    // reset values
    localparam logic [7:0] RXSC_BITCTRL_RST = 8'h80;
    localparam logic [2:0] RXSC_IRQ_RST     = 3'h0;
    // largest reportable collision index (64th bit)
    localparam logic [6:0] RXSC_COLL_MAX    = 7'h3F;
    // transmit/receive state codes
    typedef enum logic [2:0] {
        RXSC_IDLE      = 3'b000,
        RXSC_TX_WAIT   = 3'b001,
        RXSC_TX        = 3'b011,
        RXSC_RX_WAIT   = 3'b101,
        RXSC_WAIT_DATA = 3'b110,
        RXSC_RX        = 3'b111
    } rxsc_state_e;
endpackage

// File: verilog/rxsc_regs.sv
// receive status, bit control and collision register bank
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// R1 - cipher flag: host clears, auth only sets
// R2 - state code read-only, 100b never used
// R3 - keep-bit clear zeroes bits after collision
// R4 - first bit at align position, then upward
// R5 - align seven: second bit to next byte
// R6 - align zero byte-oriented, else bit-oriented
// R7 - no-collision control turns collision into integrity
// R8 - last valid bits, zero means whole
// R9 - last bits cleared at start, loaded at bit-oriented end
// R10 - position valid only when in range
// R11 - seven-bit index of first data-bit collision
// R12 - only first sixty-four bits reportable
// R13 - alignment offset added into position
// R14 - host reads position only when valid
// R15 - collision sets collision-detected flag
// R16 - collision info cleared at reception start
module rxsc_regs
    import rxsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // engine status inputs (same clock)
    input  wire logic [2:0]  txrx_state_i,
    input  wire logic        card_auth_set_i,
    input  wire logic        rx_start_i,
    input  wire logic        rx_end_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_bit_i,
    input  wire logic        rx_bit_coll_i,
    // received data stream out
    output logic             rx_byte_valid_o,
    output logic      [7:0]  rx_byte_o,
    // error flags, cipher flag and interrupt
    output logic             collision_detected_o,
    output logic             integrity_error_o,
    output logic             cipher_active_o,
    output logic             irq_o
);

    // host-visible state
    logic        cipher_active_r;     // card cipher on
    logic [2:0]  txrx_state_r;        // latched state code
    logic        keep_bits_r;         // keep bits after collision
    logic [2:0]  first_bit_pos_r;     // alignment of first bit
    logic        coll_integ_r;        // collision as integrity error
    logic [2:0]  last_valid_bits_r;   // valid bits of last byte
    logic        coll_pos_valid_r;    // position is valid
    logic [6:0]  coll_pos_r;          // first collision position
    logic [2:0]  irq_stat_r;          // sticky events
    logic [2:0]  irq_mask_r;          // interrupt enables
    // receive datapath
    logic [7:0]  shift_r;             // byte being assembled
    logic [2:0]  bit_idx_r;           // next bit position in byte
    logic [9:0]  bit_cnt_r;           // data bits counted since start
    logic        coll_seen_r;         // a collision was seen
    logic        rx_byte_valid_r;
    logic [7:0]  rx_byte_r;
    logic        coll_det_r;
    logic        integ_err_r;
    logic        ack_r;
    logic [31:0] dat_r;

    // bus decode
    logic        req;                 // new request this cycle
    logic        wr;                  // write strobe with lane 0
    logic [7:0]  idx;                 // word index
    logic        rx_bit_val;          // bit after substitution
    logic        coll_now;            // collision on this bit
    logic [9:0]  pos_full;            // position with offset
    logic [2:0]  ev;                  // events this cycle
    logic [7:0]  wbyte;               // low write byte

    // decode the word index from a byte address
    function automatic logic [7:0] word_index(input logic [9:0] a);
        word_index = a[9:2];
    endfunction

    // a request is taken once; while ack stands the held strobe is
    // not a new request, so each bus cycle acts exactly one time
    assign req   = cyc_i && stb_i && !ack_r;
    assign idx   = word_index(adr_i);
    assign wbyte = dat_i[7:0];
    assign wr    = req && we_i && sel_i[0];
    assign coll_now = rx_bit_valid_i && rx_bit_coll_i;
    // after a collision bits are zeroed unless keep is set
    assign rx_bit_val = (!keep_bits_r && (coll_seen_r || coll_now))
                        ? 1'b0 : rx_bit_i; // R3
    // collision index counts data bits plus alignment offset
    assign pos_full = bit_cnt_r + {7'h00, first_bit_pos_r}; // R11 R13
    assign ev = {rx_end_i, coll_now && coll_integ_r,
                 coll_now && !coll_seen_r};

    // wishbone ack: one cycle per request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read data mux, registered with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !we_i) begin
            case (idx)
                RXSC_IDX_STATUS: begin
                    dat_r <= {24'h000000, 2'b00, cipher_active_r,
                              2'b00, txrx_state_r}; // R2
                end
                RXSC_IDX_BITCTRL: begin
                    dat_r <= {24'h000000, keep_bits_r, first_bit_pos_r,
                              coll_integ_r, last_valid_bits_r};
                end
                RXSC_IDX_COLL: begin
                    dat_r <= {24'h000000, coll_pos_valid_r, coll_pos_r};
                end
                RXSC_IDX_IRQ_STAT: begin
                    dat_r <= {29'h00000000, irq_stat_r};
                end
                RXSC_IDX_IRQ_MASK: begin
                    dat_r <= {29'h00000000, irq_mask_r};
                end
                default: begin
                    dat_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    // state code is sampled; code 100b is shown as idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txrx_state_r <= RXSC_IDLE;
        end else if (txrx_state_i == 3'b100) begin
            txrx_state_r <= RXSC_IDLE; // R2
        end else begin
            txrx_state_r <= txrx_state_i;
        end
    end

    // cipher flag: auth sets (wins), host write of zero clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cipher_active_r <= 1'b0;
        end else if (card_auth_set_i) begin
            cipher_active_r <= 1'b1; // R1
        end else if (wr && idx == RXSC_IDX_STATUS
                     && !wbyte[RXSC_CIPHER_BIT]) begin
            cipher_active_r <= 1'b0; // R1
        end
    end

    // writable controls of the bit control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            keep_bits_r     <= RXSC_BITCTRL_RST[RXSC_KEEP_BIT];
            first_bit_pos_r <= RXSC_BITCTRL_RST[RXSC_ALIGN_LSB +: 3];
            coll_integ_r    <= RXSC_BITCTRL_RST[RXSC_COLLISION_AS_INTEGRITY_ERROR_BIT];
        end else if (wr && idx == RXSC_IDX_BITCTRL) begin
            keep_bits_r     <= wbyte[RXSC_KEEP_BIT];
            first_bit_pos_r <= wbyte[RXSC_ALIGN_LSB +: 3];
            coll_integ_r    <= wbyte[RXSC_COLLISION_AS_INTEGRITY_ERROR_BIT];
        end
    end

    // last valid bits: cleared at start, loaded at bit-oriented end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_valid_bits_r <= 3'h0;
        end else if (rx_start_i) begin
            last_valid_bits_r <= 3'h0; // R9
        end else if (rx_end_i && first_bit_pos_r != 3'h0) begin
            last_valid_bits_r <= bit_idx_r; // R8 R9
        end
    end

    // bit assembly: first bit at alignment, then upward
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_r         <= 8'h00;
            bit_idx_r       <= 3'h0;
            bit_cnt_r       <= 10'h000;
            rx_byte_valid_r <= 1'b0;
            rx_byte_r       <= 8'h00;
        end else begin
            rx_byte_valid_r <= 1'b0;
            if (rx_start_i) begin
                shift_r   <= 8'h00;
                bit_idx_r <= first_bit_pos_r; // R4 R6
                bit_cnt_r <= 10'h000;
            end else if (rx_bit_valid_i) begin
                shift_r[bit_idx_r] <= rx_bit_val; // R4
                bit_idx_r <= bit_idx_r + 3'h1;
                // stop counting at 512: far past the reportable range,
                // and the sum with the offset can never wrap back
                if (!bit_cnt_r[9]) begin
                    bit_cnt_r <= bit_cnt_r + 10'h001;
                end
                if (bit_idx_r == 3'h7) begin
                    // byte full: next bit goes to bit 0 of next byte
                    rx_byte_r       <= {rx_bit_val, shift_r[6:0]}; // R5
                    rx_byte_valid_r <= 1'b1;
                    shift_r         <= 8'h00;
                end
            end else if (rx_end_i && bit_idx_r != 3'h0) begin
                // flush a partial byte of a bit-oriented frame
                rx_byte_r       <= shift_r; // R6
                rx_byte_valid_r <= 1'b1;
            end
        end
    end

    // first collision position and validity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coll_seen_r      <= 1'b0;
            coll_pos_valid_r <= 1'b0;
            coll_pos_r       <= 7'h00;
        end else if (rx_start_i) begin
            coll_seen_r      <= 1'b0; // R16
            coll_pos_valid_r <= 1'b0; // R16
            coll_pos_r       <= 7'h00; // R16
        end else if (coll_now && !coll_seen_r) begin
            coll_seen_r <= 1'b1;
            if (pos_full <= {3'b000, RXSC_COLL_MAX}) begin
                coll_pos_r       <= pos_full[6:0]; // R11 R12 R13
                coll_pos_valid_r <= 1'b1; // R10
            end
        end
    end

    // error flags: cleared at start; collision sets detected, and integrity if coll_integ_r set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coll_det_r  <= 1'b0;
            integ_err_r <= 1'b0;
        end else if (coll_now) begin
            coll_det_r <= 1'b1; // R15
            if (coll_integ_r) begin
                integ_err_r <= 1'b1; // R7
            end
        end else if (rx_start_i) begin
            coll_det_r  <= 1'b0;
            integ_err_r <= 1'b0;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= RXSC_IRQ_RST;
        end else if (wr && idx == RXSC_IDX_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~wbyte[2:0]) | ev;
        end else begin
            irq_stat_r <= irq_stat_r | ev;
        end
    end

    // interrupt mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= RXSC_IRQ_RST;
        end else if (wr && idx == RXSC_IDX_IRQ_MASK) begin
            irq_mask_r <= wbyte[2:0];
        end
    end

    // registered interrupt level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // outputs straight from flip-flops
    assign ack_o                = ack_r;
    assign dat_o                = dat_r;
    assign rx_byte_valid_o      = rx_byte_valid_r;
    assign rx_byte_o            = rx_byte_r;
    assign collision_detected_o = coll_det_r;
    assign integrity_error_o    = integ_err_r;
    assign cipher_active_o      = cipher_active_r;

endmodule
